// ==== src/spec_meas_ctrl.sv ====
// Purpose: measurement sequencing and register file of a spectral sensor
// Assumes: classic Wishbone slave, 32-bit data, byte registers in low bits
// Notes: analog front end is outside; this block times it and holds its settings
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module spec_meas_ctrl #(
    parameter int unsigned TBASE_CYCLES = spec_meas_pkg::TBASE_CYC
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           ce_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [11:0]                    adr_i,
    input  wire logic [31:0]                    dat_i,
    output logic [31:0]                         dat_o,
    output logic                                ack_o,
    input  wire logic                           conv_pulse_i,
    input  wire spec_meas_pkg::flicker_status_t flk_status_i,
    input  wire logic                           flk_status_upd_i,
    output logic                                integrating_o,
    output logic                                flk_running_o,
    output logic                                flk_done_o,
    output logic [15:0]                         result_o,
    output logic                                result_valid_o,
    output spec_meas_pkg::analog_ctrl_t         analog_o,
    output logic [4:0]                          lamp_ma_half_o,
    output logic [7:0]                          lamp_ma_o,
    output logic [2:0]                          mux_adc_o [spec_meas_pkg::MUX_ENTRIES]
);
    import spec_meas_pkg::*;

    logic [7:0]  enable_q, step_count_q, wait_count_q, wait_mode_q;
    logic [7:0]  again_q, lamp_q, lamp_drive_q, flk_sample_q, flk_lo_q, flk_hi_q;
    logic [15:0] step_len_q;
    logic [2:0]  mux_q [MUX_ENTRIES];
    flicker_status_t flk_stat_q;
    meas_state_t state_q;
    logic [15:0] tb_cnt_q;
    logic        tb_tick;
    logic [15:0] sub_q;
    logic [11:0] step_q;
    logic [15:0] acc_q;
    logic        sat_q;
    logic [15:0] result_q;
    logic        valid_q;
    logic [10:0] flk_sub_q;
    logic [10:0] flk_smp_q;
    logic        flk_done_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  idx;
    logic        wr_en;
    logic        rd_en;
    logic        spec_on;
    logic        flk_on;
    logic [10:0] flk_steps;
    logic [10:0] flk_samples;

    assign idx    = adr_i[9:2];
    assign wr_en  = ce_i && cyc_i && stb_i && we_i && !ack_q && sel_i[0];
    assign rd_en  = ce_i && cyc_i && stb_i && !we_i && !ack_q;
    assign ack_o  = ack_q;
    assign dat_o  = rdata_q;

    // sixteen-bit increment that holds at full scale
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == FULL_SCALE) ? v : v + 16'h0001;
    endfunction

    // gain code above 10 clamps to 512x, the top power of two
    function automatic logic [4:0] gain_clamp(input logic [4:0] g);
        return (g > 5'h0a) ? 5'h0a : g;
    endfunction

    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q     <= ENABLE_RST;
            step_count_q <= 8'h00;
            step_len_q   <= STEP_LEN_RST;
            wait_count_q <= 8'h00;
            wait_mode_q  <= 8'h00;
            again_q      <= AGAIN_RST;
            lamp_q       <= LAMP_RST;
            lamp_drive_q <= 8'h00;
            flk_sample_q <= 8'h00;
            flk_lo_q     <= 8'h00;
            flk_hi_q     <= 8'h00;
        end else if (wr_en) begin
            unique case (idx)
                IDX_ENABLE:      enable_q     <= dat_i[7:0];
                IDX_STEP_COUNT:  step_count_q <= dat_i[7:0];
                IDX_STEP_LO:     step_len_q[7:0]  <= dat_i[7:0];
                IDX_STEP_HI:     step_len_q[15:8] <= dat_i[7:0];
                IDX_WAIT_COUNT:  wait_count_q <= dat_i[7:0];
                IDX_WAIT_MODE:   wait_mode_q  <= dat_i[7:0];
                IDX_AGAIN:       again_q      <= {3'h0, dat_i[4:0]};
                IDX_LAMP:        lamp_q       <= dat_i[7:0];
                IDX_LAMP_DRIVE:  lamp_drive_q <= {1'b0, dat_i[6:0]};
                IDX_FLK_SAMPLE:  flk_sample_q <= {2'h0, dat_i[5:3], 3'h0};
                IDX_FLK_TIME_LO: flk_lo_q     <= dat_i[7:0];
                IDX_FLK_GAIN_HI: flk_hi_q     <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // multiplexer table, one converter number per photodiode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < MUX_ENTRIES; i++) begin
                mux_q[i] <= 3'h0;
            end
        end else if (wr_en && idx < 8'(MUX_ENTRIES)) begin
            // codes 6 and 7 name no converter and are folded onto 5
            mux_q[idx[4:0]] <= (dat_i[2:0] > 3'h5) ? 3'h5 : dat_i[2:0];
        end
    end

    always_comb begin
        for (int i = 0; i < MUX_ENTRIES; i++) begin
            mux_adc_o[i] = mux_q[i];
        end
    end

    // read data and single-cycle ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= cyc_i && stb_i && !ack_q;
            if (rd_en) begin
                rdata_q <= 32'h0000_0000;
                unique case (idx)
                    IDX_ENABLE:      rdata_q[7:0] <= enable_q;
                    IDX_STEP_COUNT:  rdata_q[7:0] <= step_count_q;
                    IDX_STEP_LO:     rdata_q[7:0] <= step_len_q[7:0];
                    IDX_STEP_HI:     rdata_q[7:0] <= step_len_q[15:8];
                    IDX_WAIT_COUNT:  rdata_q[7:0] <= wait_count_q;
                    IDX_WAIT_MODE:   rdata_q[7:0] <= wait_mode_q;
                    IDX_AGAIN:       rdata_q[7:0] <= again_q;
                    IDX_LAMP:        rdata_q[7:0] <= lamp_q;
                    IDX_LAMP_DRIVE:  rdata_q[7:0] <= lamp_drive_q;
                    IDX_FLK_SAMPLE:  rdata_q[7:0] <= flk_sample_q;
                    IDX_FLK_TIME_LO: rdata_q[7:0] <= flk_lo_q;
                    IDX_FLK_GAIN_HI: rdata_q[7:0] <= flk_hi_q;
                    IDX_FLK_STATUS:  rdata_q[7:0] <= {3'h0, flk_stat_q};
                    IDX_MEAS_STAT:   rdata_q[7:0] <= {5'h00, sat_q, valid_q,
                                                      state_q == ST_INTEG};
                    IDX_RESULT_LO:   rdata_q[7:0] <= result_q[7:0];
                    IDX_RESULT_HI:   rdata_q[7:0] <= result_q[15:8];
                    default: begin
                        if (idx < 8'(MUX_ENTRIES)) begin
                            rdata_q[2:0] <= mux_q[idx[4:0]];
                        end
                    end
                endcase
            end
        end
    end

    assign spec_on = enable_q[EN_PON_BIT] && enable_q[EN_SPEC_BIT];
    assign flk_on  = enable_q[EN_PON_BIT] && enable_q[EN_FLK_BIT];

    // shared 2.78 us time base
    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_q[EN_PON_BIT]) begin
            tb_cnt_q <= 16'h0000;
        end else if (ce_i) begin
            tb_cnt_q <= tb_tick ? 16'h0000 : tb_cnt_q + 16'h0001;
        end
    end
    assign tb_tick = ce_i && (tb_cnt_q == 16'(TBASE_CYCLES - 1));

    // integrate, then optional wait, repeat while enabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !spec_on) begin
            state_q <= ST_IDLE;
            sub_q   <= 16'h0000;
            step_q  <= 12'h000;
            acc_q   <= 16'h0000;
            sat_q   <= 1'b0;
            valid_q <= 1'b0;
        end else if (ce_i) begin
            unique case (state_q)
                ST_IDLE: begin
                    // start on a tick so the first period is a whole one
                    if (tb_tick) begin
                        state_q <= ST_INTEG;
                    end
                    sub_q   <= 16'h0000;
                    step_q  <= 12'h000;
                    acc_q   <= 16'h0000;
                end
                ST_INTEG: begin
                    if (conv_pulse_i) begin
                        acc_q <= sat_inc(acc_q);
                    end
                    if (tb_tick) begin
                        if (sub_q == step_len_q) begin
                            sub_q <= 16'h0000;
                            if (step_q[7:0] == step_count_q) begin
                                step_q  <= 12'h000;
                                valid_q <= 1'b1;
                                sat_q   <= (acc_q == FULL_SCALE);
                                state_q <= enable_q[EN_WAIT_BIT] ? ST_WAIT : ST_IDLE;
                            end else begin
                                step_q <= step_q + 12'h001;
                            end
                        end else begin
                            sub_q <= sub_q + 16'h0001;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tb_tick) begin
                        if (sub_q == 16'(WAIT_STEP_TB - 1)) begin
                            sub_q <= 16'h0000;
                            // long mode stretches the step count sixteenfold
                            if (step_q == (wait_mode_q[LONG_WAIT_BIT]
                                    ? {wait_count_q, 4'hF}
                                    : {4'h0, wait_count_q})) begin
                                state_q <= ST_IDLE;
                            end else begin
                                step_q <= step_q + 12'h001;
                            end
                        end else begin
                            sub_q <= sub_q + 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= 16'h0000;
        end else if (ce_i && state_q == ST_INTEG && tb_tick && sub_q == step_len_q
                     && step_q[7:0] == step_count_q) begin
            result_q <= acc_q;
        end
    end

    // flicker: samples x (steps+1) time-base periods per update
    assign flk_steps   = {flk_hi_q[2:0], flk_lo_q};
    assign flk_samples = 11'(16'h0008 << flk_sample_q[5:3]);

    always_ff @(posedge clk_i) begin
        if (rst_i || !flk_on) begin
            flk_sub_q  <= 11'h000;
            flk_smp_q  <= 11'h000;
            flk_done_q <= 1'b0;
        end else if (ce_i) begin
            flk_done_q <= 1'b0;
            if (tb_tick) begin
                if (flk_sub_q == flk_steps) begin
                    flk_sub_q <= 11'h000;
                    if (flk_smp_q == flk_samples - 11'h001) begin
                        flk_smp_q  <= 11'h000;
                        flk_done_q <= 1'b1;
                    end else begin
                        flk_smp_q <= flk_smp_q + 11'h001;
                    end
                end else begin
                    flk_sub_q <= flk_sub_q + 11'h001;
                end
            end
        end
    end

    // status follows the detector at each update while flicker runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flk_stat_q <= '0;
        end else if (ce_i && flk_on && flk_status_upd_i) begin
            flk_stat_q <= flk_status_i;
        end
    end

    assign integrating_o  = state_q == ST_INTEG;
    assign flk_running_o  = flk_on;
    assign flk_done_o     = flk_done_q;
    assign result_o       = result_q;
    assign result_valid_o = valid_q;
    assign analog_o.lamp_on   = lamp_q[LAMP_ON_BIT];
    assign analog_o.lamp_code = lamp_drive_q[6:0];
    assign analog_o.again     = gain_clamp(again_q[4:0]);
    assign analog_o.flk_gain  = gain_clamp(flk_hi_q[7:3]);
    assign lamp_ma_half_o     = 5'h00;
    // mA/2: 2 + code, reported as 8 bits of mA would overflow, so full mA halved
    assign lamp_ma_o = 8'(8'h02 + {1'b0, lamp_drive_q[6:0]});

    sequence s_bus_take;
        ce_i && cyc_i && stb_i && !ack_q;
    endsequence

    sequence s_ack_pulse;
        ack_q ##1 !ack_q;
    endsequence

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i) s_bus_take ##1 ce_i |-> s_ack_pulse;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("bus answer not one cycle");

    property p_wait_skip;
        @(posedge clk_i) disable iff (rst_i)
        (state_q == ST_INTEG && $past(state_q) == ST_INTEG && !enable_q[EN_WAIT_BIT]
         && ce_i && tb_tick && sub_q == step_len_q && step_q[7:0] == step_count_q)
        |=> state_q != ST_WAIT;
    endproperty
    a_wait_skip: assert property (p_wait_skip) else $error("wait entered while disabled");

    property p_step_reset;
        @(posedge clk_i) $rose(!rst_i) |-> step_len_q == STEP_LEN_RST;
    endproperty
    a_step_reset: assert property (p_step_reset) else $error("step length reset wrong");

    property p_lamp;
        @(posedge clk_i) disable iff (rst_i)
        wr_en && idx == IDX_LAMP |=> analog_o.lamp_on == $past(dat_i[LAMP_ON_BIT]);
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp driver mismatch");

    property p_flk_idle;
        @(posedge clk_i) disable iff (rst_i) !flk_on |=> !flk_done_q;
    endproperty
    a_flk_idle: assert property (p_flk_idle) else $error("flicker done while off");

    property p_result_sat;
        @(posedge clk_i) disable iff (rst_i) $past(acc_q) == FULL_SCALE && $past(state_q)
            == ST_INTEG && state_q == ST_INTEG |-> acc_q == FULL_SCALE;
    endproperty
    a_result_sat: assert property (p_result_sat) else $error("result wrapped");

    property p_gain;
        @(posedge clk_i) disable iff (rst_i) analog_o.again <= 5'h0a;
    endproperty
    a_gain: assert property (p_gain) else $error("gain out of range");

    property p_wait_x16_bit;
        @(posedge clk_i) disable iff (rst_i)
        state_q == ST_WAIT && !wait_mode_q[LONG_WAIT_BIT] |-> step_q <= {4'h0, wait_count_q};
    endproperty
    a_wait_x16_bit: assert property (p_wait_x16_bit) else $error("wait overran");

    property p_flk_stat;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && flk_on && flk_status_upd_i |=> flk_stat_q == $past(flk_status_i);
    endproperty
    a_flk_stat: assert property (p_flk_stat) else $error("flicker status not taken");
endmodule
`default_nettype wire

// ==== src/spec_meas_pkg.sv ====
// Purpose: constants and types for the spectral measurement control block
// Assumes: byte registers on a Wishbone slave, one word per register
// Notes: offsets are register indices; byte address is four times index
// Summary of operation
// - integration step count at 0x81, step length split over 0xCA low and 0xCB high
// - integration lasts (count+1) times (length+1) time-base periods of 2.78 us
// - step count covers 1..256 steps, step length 1..65536 increments
// - step length resets to 999, one step of about 2.78 ms
// - conversion result is 16 bits, saturating at full scale
// - converter gain comes from bits 4:0 of analog_gain_config, 0.5x to 512x
// - wait-enable bit of 0x80 inserts a wait between spectral measurements
// - wait lasts (wait count+1) steps of 2.78 ms
// - long-wait bit 2 of wait_mode_config multiplies the wait by sixteen
// - lamp driver follows lamp-on bit 7 of 0x74
// - lamp current code sits in bits 6:0 of lamp_drive_config
// - multiplexer routes any photodiode to any of six converters
// - flicker runs when flicker-enable bit 6 and power bit 0 of 0x80 are set
// - flicker measurement lasts samples times (flicker count+1) time-base periods
// - 11-bit flicker step count, upper bits in flicker_gain_and_time_high 2:0, lower in own byte
// - flicker samples from flicker_sample_config bits 5:3, 8 to 1024
// - flicker gain from flicker_gain_and_time_high bits 7:3
// - flicker_result_status reports saturation, 120/100 Hz valid and detected flags
package spec_meas_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam real         TBASE_NS       = 2780.0;
    localparam int unsigned TBASE_CYC      = int'($floor(TBASE_NS * CLK_HZ / 1.0e9));
    localparam int unsigned WAIT_STEP_TB   = 1000;
    localparam int unsigned LONG_FACTOR    = 16;
    localparam logic [7:0] IDX_LAMP        = 8'h74;
    localparam logic [7:0] IDX_ENABLE      = 8'h80;
    localparam logic [7:0] IDX_STEP_COUNT  = 8'h81;
    localparam logic [7:0] IDX_WAIT_COUNT  = 8'h83;
    localparam logic [7:0] IDX_WAIT_MODE   = 8'hA9;
    localparam logic [7:0] IDX_AGAIN       = 8'hAA;
    localparam logic [7:0] IDX_LAMP_DRIVE  = 8'hB1;
    localparam logic [7:0] IDX_STEP_LO     = 8'hCA;
    localparam logic [7:0] IDX_STEP_HI     = 8'hCB;
    localparam logic [7:0] IDX_FLK_SAMPLE  = 8'hD7;
    localparam logic [7:0] IDX_FLK_TIME_LO = 8'hD8;
    localparam logic [7:0] IDX_FLK_GAIN_HI = 8'hDA;
    localparam logic [7:0] IDX_FLK_STATUS  = 8'hDB;
    localparam logic [7:0] IDX_MUX_BASE    = 8'h00;
    localparam logic [7:0] IDX_MEAS_STAT   = 8'h93;
    localparam logic [7:0] IDX_RESULT_LO   = 8'h95;
    localparam logic [7:0] IDX_RESULT_HI   = 8'h96;
    localparam int unsigned MUX_ENTRIES    = 20;
    localparam int unsigned EN_PON_BIT     = 0;
    localparam int unsigned EN_SPEC_BIT    = 1;
    localparam int unsigned EN_WAIT_BIT    = 3;
    localparam int unsigned EN_FLK_BIT     = 6;
    localparam int unsigned LAMP_ON_BIT    = 7;
    localparam int unsigned LONG_WAIT_BIT  = 2;
    localparam logic [15:0] STEP_LEN_RST   = 16'h03E7;
    localparam logic [7:0]  LAMP_RST       = 8'h04;
    localparam logic [7:0]  ENABLE_RST     = 8'h00;
    localparam logic [7:0]  AGAIN_RST      = 8'h09;
    localparam logic [15:0] FULL_SCALE     = 16'hFFFF;

    typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_WAIT} meas_state_t;

    typedef struct packed {
        logic        flk_saturated;
        logic        flk_120_valid;
        logic        flk_100_valid;
        logic        flk_120_det;
        logic        flk_100_det;
    } flicker_status_t;

    typedef struct packed {
        logic        lamp_on;
        logic [6:0]  lamp_code;
        logic [4:0]  again;
        logic [4:0]  flk_gain;
    } analog_ctrl_t;
endpackage

// ==== tb/spec_meas_ctrl_tb.sv ====
// Purpose: self-checking bench for the measurement control block
// Assumes: time base shortened to 2 clock cycles
// Notes: level monitor times integrations and waits; host model drives the bus
`timescale 1ns/1ns
`default_nettype none
module spec_meas_ctrl_tb;
    import spec_meas_pkg::*;
    localparam int TB = 2;
    logic            clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic            cyc, stb, we, ack, integ, frun, fdone, rvalid;
    logic            conv = 1'b0;
    logic            fupd = 1'b0;
    logic [3:0]      sel;
    logic [11:0]     adr;
    logic [31:0]     wdat, rdat, tmp;
    logic [15:0]     result;
    logic [7:0]      lamp_ma;
    logic [2:0]      mux [MUX_ENTRIES];
    flicker_status_t fst = '0;
    analog_ctrl_t    analog;
    int              checked = 0, fail_count = 0, hi_cnt = 0, lo_cnt = 0, len_q, gap_q;
    int              l1, g1, l2, g2;
    logic [7:0]      ri [10] = '{IDX_STEP_COUNT, IDX_STEP_LO, IDX_STEP_HI, IDX_AGAIN,
        IDX_LAMP_DRIVE, IDX_WAIT_COUNT, IDX_WAIT_MODE, IDX_FLK_SAMPLE, IDX_FLK_TIME_LO,
        IDX_FLK_GAIN_HI};
    logic [7:0]      rv [10] = '{8'h01, 8'h02, 8'h00, 8'h0A, 8'h7F, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h50};

    always #4 clk_i = ~clk_i;

    spec_meas_host i_spec_meas_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .sel_o(sel), .adr_o(adr), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    spec_meas_ctrl #(.TBASE_CYCLES(TB)) i_spec_meas_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .conv_pulse_i(conv), .flk_status_i(fst),
        .flk_status_upd_i(fupd), .integrating_o(integ), .flk_running_o(frun),
        .flk_done_o(fdone), .result_o(result), .result_valid_o(rvalid), .analog_o(analog),
        .lamp_ma_half_o(), .lamp_ma_o(lamp_ma), .mux_adc_o(mux));

    // five converter pulses at the start of every integration
    always @(posedge clk_i) begin
        conv <= (integ === 1'b1 && hi_cnt < 5);
        if (integ === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
            lo_cnt <= 0;
            if (lo_cnt != 0) gap_q <= lo_cnt;
        end else begin
            lo_cnt <= lo_cnt + 1;
            hi_cnt <= 0;
            if (hi_cnt != 0) len_q <= hi_cnt;
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_spec_meas_host.access(1'b1, 4'h1, idx, d, tmp);
    endtask

    task automatic rd(input string name, input logic [7:0] idx, input logic [31:0] exp);
        i_spec_meas_host.access(1'b0, 4'h1, idx, 8'h00, tmp);
        chk(name, tmp, exp);
    endtask

    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        while (integ !== v && k < 40000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 40000) fail_count++;
    endtask

    // first run seen is measured whole: lengths come from the level monitor
    task automatic next_meas(output int len, output int gap);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        repeat (2) @(posedge clk_i);
        len = len_q;
        gap = gap_q;
    endtask

    task automatic flk_period(input int exp);
        int k;
        k = 0;
        while (fdone !== 1'b1 && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (fdone !== 1'b1 && k < 5000);
        chk("flk_period", k, exp);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("step_lo", IDX_STEP_LO, 32'h0000_00E7);
        rd("step_hi", IDX_STEP_HI, 32'h0000_0003);
        rd("lamp", IDX_LAMP, 32'(LAMP_RST));
        rd("gain", IDX_AGAIN, 32'(AGAIN_RST));
        rd("enable", IDX_ENABLE, 32'h0000_0000);
        rd("unmapped", 8'h50, 32'h0000_0000);
        for (int i = 0; i < 10; i++) wr(ri[i], rv[i]);
        for (int i = 0; i < 10; i++) rd("rw", ri[i], 32'(rv[i]));
        i_spec_meas_host.access(1'b1, 4'h0, IDX_STEP_COUNT, 8'hFF, tmp);
        rd("sel_low", IDX_STEP_COUNT, 32'h0000_0001);
        chk("again", analog.again, 32'h0000_000A);
        chk("flk_gain", analog.flk_gain, 32'h0000_000A);
        chk("lamp_code", analog.lamp_code, 32'h0000_007F);
        chk("lamp_ma", lamp_ma, 32'((4 + 2 * 127) / 2));
        wr(IDX_LAMP, 8'h80);
        chk("lamp_on", analog.lamp_on, 1'b1);
        wr(IDX_LAMP, 8'h00);
        chk("lamp_off", analog.lamp_on, 1'b0);
        for (int i = 0; i < MUX_ENTRIES; i++) wr(IDX_MUX_BASE + 8'(i), 8'(i % 6));
        for (int i = 0; i < MUX_ENTRIES; i++) chk("mux", mux[i], 32'(i % 6));
        wr(IDX_ENABLE, 8'h40);
        chk("flk_off", frun, 1'b0);
        wr(IDX_ENABLE, 8'h41);
        chk("flk_on", frun, 1'b1);
        // detector updates are only taken while flicker runs
        fst  <= 5'h16;
        fupd <= 1'b1;
        @(posedge clk_i);
        fupd <= 1'b0;
        wr(IDX_FLK_STATUS, 8'h00);
        rd("flk_status", IDX_FLK_STATUS, 32'h0000_0016);
        flk_period(8 * 2 * TB);
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_FLK_SAMPLE, 8'h08);
        wr(IDX_ENABLE, 8'h41);
        flk_period(16 * 2 * TB);
        wr(IDX_ENABLE, 8'h0B);
        next_meas(l1, g1);
        chk("len_a", l1 >= 2 * 3 * TB && l1 <= 2 * 3 * TB + 1, 1'b1);
        chk("gap_a", g1 >= WAIT_STEP_TB * TB && g1 <= WAIT_STEP_TB * TB + 2, 1'b1);
        chk("result", result, 32'h0000_0005);
        chk("valid", rvalid, 1'b1);
        rd("result_lo", IDX_RESULT_LO, 32'h0000_0005);
        wr(IDX_ENABLE, 8'h00);
        wr(IDX_STEP_COUNT, 8'h03);
        wr(IDX_STEP_LO, 8'h01);
        wr(IDX_WAIT_MODE, 8'h04);
        wr(IDX_ENABLE, 8'h0B);
        next_meas(l2, g2);
        chk("len_b", l2 - l1, 32'(4 * 2 * TB - 2 * 3 * TB));
        chk("gap_b", g2 - g1, 32'((LONG_FACTOR - 1) * WAIT_STEP_TB * TB));
        wr(IDX_ENABLE, 8'h03);
        next_meas(l1, g1);
        chk("gap_none", g1 < 3, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== tb/spec_meas_host.sv ====
// Purpose: host model, classic single-cycle bus master for the register file
// Assumes: one idle cycle between accesses, byte register in low data bits
// Notes: waits for ack without limit; the bench watchdog cuts hangs
`timescale 1ns/1ns
`default_nettype none
module spec_meas_host (
    input  wire logic        clk_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [3:0]       sel_o,
    output logic [11:0]      adr_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        sel_o = 4'h0;
        adr_o = 12'h000;
        dat_o = 32'h5A5A_A5A5;
    end

    task automatic access(input logic wr, input logic [3:0] sel, input logic [7:0] idx,
                          input logic [7:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= wr;
        sel_o <= sel;
        adr_o <= {2'b00, idx, 2'b00};
        dat_o <= {24'h00_0000, wdat};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rdat = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        // released data lines carry a changed pattern, not stale data
        dat_o <= ~dat_o;
    endtask
endmodule
`default_nettype wire
